// [rtl/rqp_pkg.sv]
// shared constants, types and helpers of the request stream port
package rqp_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DW_DEF   = 256;  // default request bus width
    localparam int DW_MIN   = 64;
    localparam int DW_MID   = 128;
    localparam int DW_MAX   = 256;
    localparam int DWORD_W  = 32;   // one keep bit per dword lane
    localparam int KEEP_W   = 8;    // keep bus sized for widest bus
    localparam int SEQ_W    = 4;
    localparam int TAG_W    = 6;
    localparam int LEN_W    = 11;   // packet length in dwords
    localparam int BUF_DEPTH = 2;

    // ------------------------------------------------------------
    // reset values and the all-lanes keep pattern
    // ------------------------------------------------------------
    localparam logic [TAG_W-1:0] TAG_RST = 6'h00;
    localparam logic [SEQ_W-1:0] SEQ_RST = 4'h0;
    localparam logic [KEEP_W-1:0] KEEP_ALL = 8'hff;

    // ------------------------------------------------------------
    // client sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_SEND = 2'h2
    } rqp_state_t;

    // lanes in use for a bus width; upper keep bits are don't-care
    function automatic logic [KEEP_W-1:0] rqp_lane_mask(input int dw);
        return KEEP_ALL >> (KEEP_W - dw / DWORD_W);
    endfunction : rqp_lane_mask

    // keep pattern for a beat with rem dwords left to send
    function automatic logic [KEEP_W-1:0] rqp_keep_for(
        input logic [LEN_W-1:0] rem,
        input int               dw
    );
        logic [15:0] ones;
        ones = 16'h0000;
        if (int'(rem) >= dw / DWORD_W) begin
            return rqp_lane_mask(dw);
        end
        ones = (16'h0001 << rem[3:0]) - 16'h0001;
        return ones[KEEP_W-1:0];
    endfunction : rqp_keep_for

endpackage : rqp_pkg

// [rtl/rqp_if.sv]
// link between client end and core end of the request stream port
`timescale 1ns/10ps
interface rqp_if #(
    parameter int DW = rqp_pkg::DW_DEF
);
    logic [DW-1:0]                 req_stream_data;
    logic [rqp_pkg::KEEP_W-1:0]    req_stream_keep;
    logic                          req_stream_last;
    logic                          req_stream_valid;
    logic                          req_stream_ready;
    logic                          req_np;           // first beat: non-posted
    logic [rqp_pkg::SEQ_W-1:0]     req_seq_in;
    logic [rqp_pkg::SEQ_W-1:0]     req_seq_out;
    logic                          req_seq_out_valid;
    logic [rqp_pkg::TAG_W-1:0]     req_tag_out;
    logic                          req_tag_out_valid;

    // the documented core
    modport core (
        input  req_stream_data, req_stream_keep, req_stream_last,
        input  req_stream_valid, req_np, req_seq_in,
        output req_stream_ready, req_seq_out, req_seq_out_valid,
        output req_tag_out, req_tag_out_valid
    );

    // the requesting client
    modport client (
        output req_stream_data, req_stream_keep, req_stream_last,
        output req_stream_valid, req_np, req_seq_in,
        input  req_stream_ready, req_seq_out, req_seq_out_valid,
        input  req_tag_out, req_tag_out_valid
    );
endinterface : rqp_if

// [rtl/rqp_core_end.sv]
// core end: request ingress with two-entry buffer, sequence echo and tags
`timescale 1ns/10ps
module rqp_core_end #(
    parameter int DW = rqp_pkg::DW_DEF
) (
    input  wire logic                        i_clk,             // clock
    input  wire logic                        i_rst,             // async reset
    input  wire logic                        i_ce,              // clock enable
    input  wire logic                        i_client_tag_mode, // 1: client tags
    rqp_if.core                              rq,                // request link
    output logic [DW-1:0]                    o_pkt_data,        // beat data
    output logic [rqp_pkg::KEEP_W-1:0]       o_pkt_keep,        // lane keep
    output logic                             o_pkt_last,        // last beat
    output logic                             o_pkt_valid,       // beat valid
    input  wire logic                        i_pkt_ready        // downstream ready
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (DW != rqp_pkg::DW_MIN && DW != rqp_pkg::DW_MID
        && DW != rqp_pkg::DW_MAX) begin : g_bad_dw
        $error("rqp_core_end: DW must be 64, 128 or 256");
    end

    localparam int SW = rqp_pkg::SEQ_W;
    localparam int EW = DW + rqp_pkg::KEEP_W + 1 + SW;
    localparam logic [rqp_pkg::KEEP_W-1:0] LANE_MASK =
        rqp_pkg::rqp_lane_mask(DW);

    // ------------------------------------------------------------
    // input decode
    // ------------------------------------------------------------
    logic [EW-1:0]           mem [rqp_pkg::BUF_DEPTH];
    logic                    wptr;
    logic                    rptr;
    logic [1:0]              count;
    logic                    in_sop;
    logic [SW-1:0]           seq_hold;
    logic [rqp_pkg::TAG_W-1:0] next_tag;

    wire in_fire  = rq.req_stream_valid & rq.req_stream_ready;
    wire out_fire = o_pkt_valid & i_pkt_ready;
    // unused lanes are dropped so stray keep bits never reach downstream
    wire [rqp_pkg::KEEP_W-1:0] keep_used =
        rq.req_stream_keep & LANE_MASK;
    wire [SW-1:0] beat_seq = in_sop ? rq.req_seq_in : seq_hold;
    wire [EW-1:0] in_word  =
        {beat_seq, rq.req_stream_last, keep_used, rq.req_stream_data};
    wire [EW-1:0] head     = mem[rptr];
    wire          tag_req  =
        in_fire & in_sop & rq.req_np & ~i_client_tag_mode;

    // full stalls the client; a pop and push in one cycle while full
    // is not taken, trading a cycle of throughput for a plain ready
    assign rq.req_stream_ready = (count != 2'h2);
    assign o_pkt_valid = (count != 2'h0);
    assign o_pkt_data  = head[DW-1:0];
    assign o_pkt_keep  = head[DW +: rqp_pkg::KEEP_W];
    assign o_pkt_last  = head[DW + rqp_pkg::KEEP_W];

    // ------------------------------------------------------------
    // buffer storage
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_ce && in_fire) begin
            mem[wptr] <= in_word;
        end
    end

    // buffer pointers and occupancy
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wptr  <= 1'h0;
            rptr  <= 1'h0;
            count <= 2'h0;
        end else if (i_ce) begin
            wptr  <= wptr ^ in_fire;
            rptr  <= rptr ^ out_fire;
            count <= count + {1'h0, in_fire} - {1'h0, out_fire};
        end
    end

    // packet framing: next beat after a last beat opens a new packet
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            in_sop   <= 1'h1;
            seq_hold <= rqp_pkg::SEQ_RST;
        end else if (i_ce && in_fire) begin
            in_sop   <= rq.req_stream_last;
            seq_hold <= beat_seq;
        end
    end

    // ------------------------------------------------------------
    // sequence echo
    // ------------------------------------------------------------
    // a packet whose last beat left the buffer can no longer be passed
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rq.req_seq_out       <= rqp_pkg::SEQ_RST;
            rq.req_seq_out_valid <= 1'h0;
        end else if (i_ce) begin
            rq.req_seq_out_valid <= out_fire & o_pkt_last;
            if (out_fire && o_pkt_last) begin
                rq.req_seq_out <= head[EW-1 -: SW];
            end
        end
    end

    // ------------------------------------------------------------
    // tag allocation
    // ------------------------------------------------------------
    // tags are granted in acceptance order, one cycle after the first
    // beat; no reclaim is tracked, the counter simply wraps
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            next_tag             <= rqp_pkg::TAG_RST;
            rq.req_tag_out       <= rqp_pkg::TAG_RST;
            rq.req_tag_out_valid <= 1'h0;
        end else if (i_ce) begin
            rq.req_tag_out_valid <= tag_req;
            if (tag_req) begin
                rq.req_tag_out <= next_tag;
                next_tag       <= next_tag + 6'h01;
            end
        end
    end

endmodule : rqp_core_end

// [rtl/rqp_client_end.sv]
// client end: frames commands into request packets and tracks tags
`timescale 1ns/10ps
module rqp_client_end #(
    parameter int DW = rqp_pkg::DW_DEF
) (
    input  wire logic                        i_clk,        // clock
    input  wire logic                        i_rst,        // async reset
    input  wire logic                        i_ce,         // clock enable
    input  wire logic                        i_cmd_valid,  // command offered
    output logic                             o_cmd_ready,  // command taken
    input  wire logic                        i_cmd_np,     // non-posted request
    input  wire logic [rqp_pkg::SEQ_W-1:0]   i_cmd_seq,    // sequence number
    input  wire logic [rqp_pkg::LEN_W-1:0]   i_cmd_len,    // dwords, 0 as 1
    input  wire logic [31:0]                 i_cmd_base,   // first dword value
    rqp_if.client                            rq,           // request link
    output logic                             o_seq_valid,  // sequence echoed
    output logic [rqp_pkg::SEQ_W-1:0]        o_seq,        // echoed number
    output logic                             o_tag_valid,  // tag received
    output logic [rqp_pkg::TAG_W-1:0]        o_tag,        // received tag
    input  wire logic                        i_cpl_valid,  // completion seen
    input  wire logic [rqp_pkg::TAG_W-1:0]   i_cpl_tag,    // its tag
    output logic                             o_cpl_hit,    // tag outstanding
    output logic                             o_cpl_miss    // tag unknown
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (DW != rqp_pkg::DW_MIN && DW != rqp_pkg::DW_MID
        && DW != rqp_pkg::DW_MAX) begin : g_bad_dw
        $error("rqp_client_end: DW must be 64, 128 or 256");
    end

    localparam int LW    = rqp_pkg::LEN_W;
    localparam int LANES = DW / rqp_pkg::DWORD_W;
    localparam logic [LW-1:0] LANES_L = LW'(LANES);
    localparam int NTAG  = 2 ** rqp_pkg::TAG_W;

    // one beat of the counting pattern: lane i holds word + i
    function automatic logic [DW-1:0] fill(input logic [31:0] word);
        logic [DW-1:0] d;
        d = '0;
        for (int i = 0; i < LANES; i++) begin
            d[i*32 +: 32] = word + 32'(i);
        end
        return d;
    endfunction : fill

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    rqp_pkg::rqp_state_t    state;
    rqp_pkg::rqp_state_t    next_state;
    logic [LW-1:0]          rem;
    logic [31:0]            word;
    logic [NTAG-1:0]        tag_busy;

    wire          fire     = rq.req_stream_valid & rq.req_stream_ready;
    wire          cmd_take = i_cmd_valid & o_cmd_ready;
    wire [LW-1:0] len_eff  = (i_cmd_len == '0) ? LW'(1) : i_cmd_len;
    // the beat to load comes from the command or from the running count
    wire [LW-1:0] load_rem  = cmd_take ? len_eff : rem;
    wire [31:0]   load_word = cmd_take ? i_cmd_base : word;
    wire          load_last = (load_rem <= LANES_L);
    wire          load_beat = cmd_take | (fire & ~rq.req_stream_last);
    wire          done_beat = fire & rq.req_stream_last;

    assign o_cmd_ready = (state == rqp_pkg::ST_IDLE);

    // next state: one packet at a time, idle only after its last beat
    always_comb begin
        next_state = state;
        case (state)
            rqp_pkg::ST_IDLE: begin
                if (cmd_take) begin
                    next_state = rqp_pkg::ST_SEND;
                end
            end
            rqp_pkg::ST_SEND: begin
                if (done_beat) begin
                    next_state = rqp_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = rqp_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= rqp_pkg::ST_IDLE;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // beat registers
    // ------------------------------------------------------------
    // valid rises with the first beat and falls only after the last one
    // is taken, so the core alone paces the packet
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rq.req_stream_valid <= 1'h0;
        end else if (i_ce) begin
            if (load_beat) begin
                rq.req_stream_valid <= 1'h1;
            end else if (done_beat) begin
                rq.req_stream_valid <= 1'h0;
            end
        end
    end

    // data and qualifiers change only on a load, so a stall holds them
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rq.req_stream_data <= '0;
            rq.req_stream_keep <= '0;
            rq.req_stream_last <= 1'h0;
            rem                <= '0;
            word               <= 32'h0000_0000;
        end else if (i_ce && load_beat) begin
            rq.req_stream_data <= fill(load_word);
            // full beats keep every lane in use, only a short tail is partial
            rq.req_stream_keep <= rqp_pkg::rqp_keep_for(load_rem, DW);
            rq.req_stream_last <= load_last;
            rem                <= load_rem - LANES_L;
            word               <= load_word + 32'(LANES);
        end
    end

    // packet-wide sideband, held for every beat of the packet
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rq.req_np     <= 1'h0;
            rq.req_seq_in <= rqp_pkg::SEQ_RST;
        end else if (i_ce && cmd_take) begin
            rq.req_np     <= i_cmd_np;
            rq.req_seq_in <= i_cmd_seq;
        end
    end

    // ------------------------------------------------------------
    // sequence and tag capture
    // ------------------------------------------------------------
    // echoed numbers and tags are one-cycle pulses; catch them at once
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_seq_valid <= 1'h0;
            o_seq       <= rqp_pkg::SEQ_RST;
            o_tag_valid <= 1'h0;
            o_tag       <= rqp_pkg::TAG_RST;
        end else if (i_ce) begin
            o_seq_valid <= rq.req_seq_out_valid;
            o_tag_valid <= rq.req_tag_out_valid;
            if (rq.req_seq_out_valid) begin
                o_seq <= rq.req_seq_out;
            end
            if (rq.req_tag_out_valid) begin
                o_tag <= rq.req_tag_out;
            end
        end
    end

    // ------------------------------------------------------------
    // outstanding tag table
    // ------------------------------------------------------------
    wire             cpl_known = tag_busy[i_cpl_tag];
    wire [NTAG-1:0]  tag_set   =
        rq.req_tag_out_valid ? (NTAG'(1) << rq.req_tag_out) : '0;
    wire [NTAG-1:0]  tag_clr   =
        (i_cpl_valid & cpl_known) ? (NTAG'(1) << i_cpl_tag) : '0;

    // a tag granted in the cycle its old completion retires stays busy
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tag_busy <= '0;
        end else if (i_ce) begin
            tag_busy <= (tag_busy & ~tag_clr) | tag_set;
        end
    end

    // completion lookup result, one cycle after the completion
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cpl_hit  <= 1'h0;
            o_cpl_miss <= 1'h0;
        end else if (i_ce) begin
            o_cpl_hit  <= i_cpl_valid & cpl_known;
            o_cpl_miss <= i_cpl_valid & ~cpl_known;
        end
    end

endmodule : rqp_client_end

// [testbench/rqp_link_asserts.sv]
// checker for the request link between client end and core end
`timescale 1ns/10ps
module rqp_link_asserts #(
    parameter int DW = rqp_pkg::DW_DEF
) (
    input wire logic                       i_clk,             // clock
    input wire logic                       i_rst,             // async reset
    input wire logic                       i_client_tag_mode, // 1: client tags
    input wire logic [DW-1:0]              req_stream_data,   // beat data
    input wire logic [rqp_pkg::KEEP_W-1:0] req_stream_keep,   // lane keep
    input wire logic                       req_stream_last,   // last beat
    input wire logic                       req_stream_valid,  // beat offered
    input wire logic                       req_stream_ready,  // core ready
    input wire logic                       req_np,            // non-posted
    input wire logic [rqp_pkg::SEQ_W-1:0]  req_seq_in,        // client number
    input wire logic [rqp_pkg::SEQ_W-1:0]  req_seq_out,       // echoed number
    input wire logic                       req_seq_out_valid, // echo pulse
    input wire logic [rqp_pkg::TAG_W-1:0]  req_tag_out,       // tag
    input wire logic                       req_tag_out_valid  // tag pulse
);
    // ------------------------------------------------------------
    // bookkeeping
    // ------------------------------------------------------------
    localparam logic [7:0] LANE_MASK = 8'hff >> (8 - DW / 32);
    logic       in_pkt;   // between first and last beat
    logic [5:0] tag_exp;  // next tag owed, counted from 0
    logic [2:0] pend;     // last beats taken whose echo is still owed
    wire fire     = req_stream_valid && req_stream_ready;
    wire first_np = fire && !in_pkt && req_np && !i_client_tag_mode;

    // counters and the in-packet flag only; kept apart from the properties so each stays readable
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            in_pkt  <= 1'b0;
            tag_exp <= 6'h00;
            pend    <= 3'h0;
        end else begin
            in_pkt  <= fire ? !req_stream_last : in_pkt;
            tag_exp <= tag_exp + {5'h00, req_tag_out_valid};
            pend    <= pend + {2'h0, fire && req_stream_last} - {2'h0, req_seq_out_valid};
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_hold_on_stall: assert property (req_stream_valid && !req_stream_ready |=>
        req_stream_valid && $stable(req_stream_data) && $stable(req_stream_keep)
        && $stable(req_stream_last) && $stable(req_seq_in)) else $error("stalled beat moved");
    a_valid_in_pkt: assert property (fire && !req_stream_last |=> req_stream_valid)
        else $error("valid dropped inside packet");
    a_gap_after_last: assert property (fire && req_stream_last |=> !req_stream_valid)
        else $error("no gap after last beat");
    a_keep_contig: assert property (req_stream_valid |-> req_stream_keep[0] &&
        (req_stream_keep & (req_stream_keep + 8'h01)) == 8'h00) else $error("keep has holes");
    a_keep_full_mid: assert property (req_stream_valid && !req_stream_last |->
        req_stream_keep == LANE_MASK) else $error("partial keep before last beat");
    a_tag_after_np: assert property (first_np |=> req_tag_out_valid)
        else $error("tag not reported");
    a_tag_has_cause: assert property (req_tag_out_valid |-> $past(first_np))
        else $error("tag pulse without request");
    a_tag_in_order: assert property (req_tag_out_valid |-> req_tag_out == tag_exp)
        else $error("tag out of order");
    a_seq_owed: assert property (req_seq_out_valid |-> pend != 3'h0)
        else $error("echo without a taken packet");

    c_stall: cover property (req_stream_valid && !req_stream_ready);
    c_np_tag: cover property (first_np ##1 req_tag_out_valid);
    c_echo: cover property (req_seq_out_valid);
endmodule : rqp_link_asserts

// [testbench/tb_top.sv]
// self-checking bench: client end and core end joined by the request link
`timescale 1ns/10ps
module tb_top;
    // ------------------------------------------------------------
    // set-up
    // ------------------------------------------------------------
    localparam int DW    = rqp_pkg::DW_MID;  // 128 bits leaves keep bits 7:4 unused
    localparam int LANES = DW / 32;
    typedef struct {
        logic [DW-1:0] d;
        logic [7:0]    k;
        logic          l;
    } rqp_beat_t;
    logic          i_clk = 1'b0;
    logic          i_rst = 1'b1;
    logic          i_cmd_valid = 1'b0;
    logic          i_cmd_np = 1'b0;
    logic [3:0]    i_cmd_seq = 4'h0;
    logic [10:0]   i_cmd_len = 11'h000;
    logic [31:0]   i_cmd_base = 32'h0000_0000;
    logic          i_pkt_ready = 1'b1;
    logic          i_client_tag_mode = 1'b0;
    logic          i_cpl_valid = 1'b0;
    logic [5:0]    i_cpl_tag = 6'h00;
    logic          o_cmd_ready, o_pkt_last, o_pkt_valid, o_seq_valid, o_tag_valid;
    logic          o_cpl_hit, o_cpl_miss;
    logic [DW-1:0] o_pkt_data;
    logic [7:0]    o_pkt_keep;
    logic [3:0]    o_seq;
    logic [5:0]    o_tag;
    int            n_fail = 0;
    int            n_tests = 0;
    int            stall_pct = 0;  // chance in percent of a downstream stall
    int            n_np = 0;       // tags the core still owes
    int            lens[8] = '{0, 1, 3, 4, 5, 8, 9, 12};
    logic [5:0]    tag_next = 6'h00;
    rqp_beat_t     beat_q[$], mb;
    logic [3:0]    seq_q[$], ms;

    `define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
        $display("Error %s expected %h seen %h", what, exp, got); end end

    always #4 i_clk = ~i_clk;

    rqp_if #(.DW(DW)) link ();
    rqp_client_end #(.DW(DW)) rqp_client_end_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_cmd_valid(i_cmd_valid),
        .o_cmd_ready(o_cmd_ready), .i_cmd_np(i_cmd_np), .i_cmd_seq(i_cmd_seq),
        .i_cmd_len(i_cmd_len), .i_cmd_base(i_cmd_base), .rq(link), .o_seq_valid(o_seq_valid),
        .o_seq(o_seq), .o_tag_valid(o_tag_valid), .o_tag(o_tag), .i_cpl_valid(i_cpl_valid),
        .i_cpl_tag(i_cpl_tag), .o_cpl_hit(o_cpl_hit), .o_cpl_miss(o_cpl_miss));
    rqp_core_end #(.DW(DW)) rqp_core_end_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_client_tag_mode(i_client_tag_mode),
        .rq(link), .o_pkt_data(o_pkt_data), .o_pkt_keep(o_pkt_keep), .o_pkt_last(o_pkt_last),
        .o_pkt_valid(o_pkt_valid), .i_pkt_ready(i_pkt_ready));
    rqp_link_asserts #(.DW(DW)) rqp_link_asserts_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_client_tag_mode(i_client_tag_mode),
        .req_stream_data(link.req_stream_data), .req_stream_keep(link.req_stream_keep),
        .req_stream_last(link.req_stream_last), .req_stream_valid(link.req_stream_valid),
        .req_stream_ready(link.req_stream_ready), .req_np(link.req_np),
        .req_seq_in(link.req_seq_in), .req_seq_out(link.req_seq_out),
        .req_seq_out_valid(link.req_seq_out_valid), .req_tag_out(link.req_tag_out),
        .req_tag_out_valid(link.req_tag_out_valid));

    // ------------------------------------------------------------
    // expectations and drivers
    // ------------------------------------------------------------
    function automatic logic [DW-1:0] lane_bits(input logic [7:0] k);
        logic [DW-1:0] m;
        for (int j = 0; j < LANES; j++) begin
            m[32*j +: 32] = {32{k[j]}};
        end
        return m;
    endfunction : lane_bits

    // beats due downstream for one command; a length of 0 counts as 1 dword
    function automatic void expect_cmd(input logic [10:0] len, input logic [31:0] base,
                                       input logic [3:0] seq, input logic np);
        int        n;
        rqp_beat_t b;
        n = (len == 11'h000) ? 1 : int'(len);
        for (int i = 0; i < n; i += LANES) begin
            b.k = (n - i >= LANES) ? 8'hff >> (8 - LANES) : 8'((1 << (n - i)) - 1);
            b.l = (i + LANES >= n);
            for (int j = 0; j < LANES; j++) begin
                b.d[32*j +: 32] = base + 32'(i + j);
            end
            beat_q.push_back(b);
        end
        seq_q.push_back(seq);
        n_np += (np && !i_client_tag_mode) ? 1 : 0;
    endfunction : expect_cmd

    task automatic send(input logic np, input logic [3:0] seq, input logic [10:0] len,
                        input logic [31:0] base);
        @(negedge i_clk);
        i_cmd_valid = 1'b1;
        i_cmd_np    = np;
        i_cmd_seq   = seq;
        i_cmd_len   = len;
        i_cmd_base  = base;
        for (int k = 0; k < 5000 && o_cmd_ready !== 1'b1; k++) begin
            @(negedge i_clk);
        end
        `CHK("cmd_ready", 1'b1, o_cmd_ready)
        expect_cmd(len, base, seq, np);
        @(negedge i_clk);
        i_cmd_valid = 1'b0;
    endtask : send

    task automatic drain;
        for (int k = 0; k < 5000 && beat_q.size() + seq_q.size() != 0; k++) begin
            @(negedge i_clk);
        end
        repeat (4) @(negedge i_clk);
        `CHK("drained", 0, beat_q.size() + seq_q.size())
    endtask : drain

    task automatic cpl(input logic [5:0] t, input logic hit);
        @(negedge i_clk);
        i_cpl_valid = 1'b1;
        i_cpl_tag   = t;
        @(negedge i_clk);
        i_cpl_valid = 1'b0;
        `CHK("cpl_hit", hit, o_cpl_hit)
        `CHK("cpl_miss", !hit, o_cpl_miss)
    endtask : cpl

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    // downstream stalls drawn here; the next edge takes the handshake seen
    always @(negedge i_clk) begin
        i_pkt_ready = ($urandom_range(99) >= stall_pct);
        if (!i_rst && o_pkt_valid === 1'b1 && i_pkt_ready) begin
            if (beat_q.size() == 0) begin
                `CHK("pkt_owed", 1'b1, 1'b0)
            end else begin
                mb = beat_q.pop_front();
                `CHK("pkt_keep", mb.k, o_pkt_keep)
                `CHK("pkt_last", mb.l, o_pkt_last)
                `CHK("pkt_data", mb.d & lane_bits(mb.k), o_pkt_data & lane_bits(mb.k))
            end
        end
        if (o_seq_valid === 1'b1) begin
            ms = (seq_q.size() > 0) ? seq_q.pop_front() : 4'hx;
            `CHK("seq", ms, o_seq)
        end
        if (o_tag_valid === 1'b1) begin
            `CHK("tag", tag_next, o_tag)
            tag_next++;
            n_np--;
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(12));
        repeat (8) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        // awkward lengths, first with a free downstream, then a stalling one
        for (int p = 0; p < 2; p++) begin
            stall_pct = 60 * p;
            foreach (lens[c]) send(1'((c + p) % 2), 4'(c), 11'(lens[c]), $urandom);
        end
        drain();
        // longest packet against a blocked downstream fills the buffer
        stall_pct = 100;
        send(1'b1, 4'h9, 11'h7ff, 32'hffff_fff0);
        repeat (20) @(negedge i_clk);
        `CHK("stream_ready", 1'b0, link.req_stream_ready)
        stall_pct = 30;
        repeat (40) send(1'($urandom_range(1)), 4'($urandom), 11'($urandom_range(64)), $urandom);
        drain();
        `CHK("tags_owed", 0, n_np)
        // client-managed tags: any tag pulse now drives the count below zero
        i_client_tag_mode = 1'b1;
        repeat (10) send(1'b1, 4'($urandom), 11'($urandom_range(20)), $urandom);
        drain();
        `CHK("tags_owed", 0, n_np)
        cpl(tag_next - 6'h01, 1'b1);
        cpl(tag_next - 6'h01, 1'b0);
        wrap_up();
    end

    // hang guard, well past the few thousand cycles needed
    initial begin
        repeat (60000) @(posedge i_clk);
        n_fail++;
        wrap_up();
    end
endmodule : tb_top
